/* design/efc_pkg.sv */
// package: constants for the embedded flash controller
package efc_pkg;
  localparam int unsigned PAGES = 80;
  localparam int unsigned ROWS_PER_PAGE = 8;
  localparam int unsigned WORDS_PER_ROW = 64;
  localparam int unsigned TOTAL_WORDS = 40960;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned WORD_IDX_LSB = 0;
  localparam int unsigned WORD_IDX_W = 6;
  localparam int unsigned ROW_LSB = 6;
  localparam int unsigned ROW_W = 3;
  localparam int unsigned PAGE_LSB = 9;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned WORDS_PER_PAGE = 512;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h11;
  localparam logic [7:0] CMD_ARRAY_CLEAR = 8'h22;
  localparam logic [7:0] CMD_WORD_PROGRAM = 8'h33;
  localparam logic [7:0] CMD_BURST_PROGRAM = 8'hcc;
  localparam int unsigned BURST_WORDS = 4;
  localparam logic [31:0] ERASED_WORD = 32'hffffffff;
  localparam logic [31:0] DATA_RESET = 32'hffffffff;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ERASE_TIME_US = 21500;
  localparam int unsigned PROG_TIME_US = 44;
  localparam int unsigned BURST_STEP_US = 21;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned BURST_STEP_CYCLES = BURST_STEP_US * CLK_MHZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage : efc_pkg

/* design/efc_mem_if.sv */
// interface: array access port between sequencer and storage
`timescale 1ns/10ps
`default_nettype none
interface efc_mem_if;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic prog;
  logic erase_page;
  logic erase_all;
  logic [31:0] rdata;
  modport ctrl (output addr, output wdata, output prog, output erase_page,
                output erase_all, input rdata);
  modport mem (input addr, input wdata, input prog, input erase_page,
               input erase_all, output rdata);
endinterface : efc_mem_if
`default_nettype wire

/* design/efc_array.sv */
// module: flash storage model with and-only program and page/array erase
`timescale 1ns/10ps
`default_nettype none
module efc_array #(
  parameter int unsigned WORDS = 40960
) (
  input wire logic mclk, // system clock
  efc_mem_if.mem m // array port
);
  logic [31:0] mem_q [WORDS];
  logic [31:0] rdata_q;
  logic [efc_pkg::PAGE_W-1:0] pg;

  assign pg = m.addr[efc_pkg::PAGE_LSB +: efc_pkg::PAGE_W];

  // no reset: stored content survives reset like real flash
  always_ff @(posedge mclk) begin
    for (int i = 0; i < WORDS; i++) begin
      if (m.erase_all || (m.erase_page && (i / efc_pkg::WORDS_PER_PAGE) == int'(pg))) begin
        mem_q[i] <= efc_pkg::ERASED_WORD;
      end else if (m.prog && int'(m.addr) == i) begin
        mem_q[i] <= mem_q[i] & m.wdata;
      end
    end
    rdata_q <= (int'(m.addr) < WORDS) ? mem_q[m.addr] : efc_pkg::ERASED_WORD;
  end
  assign m.rdata = rdata_q;
endmodule : efc_array
`default_nettype wire

/* design/efc_ctrl.sv */
// module: embedded flash controller top, ahb read slave and program/erase sequencer
`timescale 1ns/10ps
`default_nettype none
module efc_ctrl #(
  parameter int unsigned WORDS = efc_pkg::TOTAL_WORDS,
  parameter int unsigned ERASE_CYC = efc_pkg::ERASE_CYCLES,
  parameter int unsigned PROG_CYC = efc_pkg::PROG_CYCLES,
  parameter int unsigned STEP_CYC = efc_pkg::BURST_STEP_CYCLES
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write (ignored, array is read-only)
  input wire logic hready, // ahb ready in
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic [1:0] hresp, // ahb response
  input wire logic cmd_wr, // command write strobe
  input wire logic [7:0] cmd_code, // command code
  input wire logic addr_wr, // program address write strobe
  input wire logic [15:0] addr_in, // program address value
  input wire logic [3:0] data_wr, // data word write strobes
  input wire logic [31:0] data_in, // data word value
  input wire logic accepted_clr, // write-one clear of accepted flag
  input wire logic complete_clr, // write-one clear of complete flag
  output logic command_accepted_flag, // command taken
  output logic command_complete_flag, // command finished
  output logic busy, // operation in progress
  output logic [15:0] prog_addr // current program address
);
  typedef enum logic [2:0] {S_IDLE, S_ERASE, S_PROG, S_WAIT, S_DONE} efc_state_e;

  efc_mem_if mif ();
  efc_array #(.WORDS(WORDS)) u_array (.mclk(mclk), .m(mif));

  efc_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [15:0] addr_q, addr_d;
  logic [31:0] data_q [4];
  logic [31:0] data_d [4];
  logic [1:0] widx_q, widx_d;
  logic [1:0] wlast_q, wlast_d;
  logic all_q, all_d;
  logic acc_q, acc_d, cmp_q, cmp_d;
  logic rd_pend_q, rd_pend_d;
  logic [15:0] rd_addr_q, rd_addr_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q, hreadyout_d;
  logic busy_q, busy_d;
  logic prog_p, erase_p;

  function automatic logic cmd_valid(input logic [7:0] c);
    return c == efc_pkg::CMD_PAGE_ERASE || c == efc_pkg::CMD_ARRAY_CLEAR ||
           c == efc_pkg::CMD_WORD_PROGRAM || c == efc_pkg::CMD_BURST_PROGRAM;
  endfunction : cmd_valid

  logic idle_cmd;
  assign idle_cmd = (state_q == S_IDLE) && !cmp_q && !acc_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    data_d = data_q;
    widx_d = widx_q;
    wlast_d = wlast_q;
    all_d = all_q;
    acc_d = acc_q && !accepted_clr;
    cmp_d = cmp_q && !complete_clr;
    prog_p = 1'b0;
    erase_p = 1'b0;
    if (state_q == S_IDLE && addr_wr) begin
      addr_d = addr_in;
    end
    for (int i = 0; i < efc_pkg::BURST_WORDS; i++) begin
      if (state_q == S_IDLE && data_wr[i]) begin
        data_d[i] = data_in;
      end
    end
    unique case (state_q)
      S_IDLE: begin
        // started only by a command write
        // ignore command while previous flags pending
        if (cmd_wr && idle_cmd && cmd_valid(cmd_code)) begin
          acc_d = 1'b1;
          widx_d = 2'h0;
          cnt_d = 32'h0;
          all_d = (cmd_code == efc_pkg::CMD_ARRAY_CLEAR);
          wlast_d = (cmd_code == efc_pkg::CMD_BURST_PROGRAM) ? 2'h3 : 2'h0;
          if (cmd_code == efc_pkg::CMD_PAGE_ERASE || cmd_code == efc_pkg::CMD_ARRAY_CLEAR) begin
            state_d = S_ERASE;
          end else begin
            state_d = S_PROG;
          end
        end
      end
      S_ERASE: begin
        // erase strobed once, on the last cycle of the erase time
        if (cnt_q == 32'(ERASE_CYC - 1)) begin
          erase_p = 1'b1;
          state_d = S_DONE;
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      S_PROG: begin
        // one word per step; burst skips all-ones words
        if (data_q[widx_q] != efc_pkg::ERASED_WORD || wlast_q == 2'h0) begin
          prog_p = 1'b1;
        end
        cnt_d = 32'h0;
        state_d = S_WAIT;
      end
      S_WAIT: begin
        if (cnt_q == 32'((widx_q == 2'h0 ? PROG_CYC : STEP_CYC) - 1)) begin
          if (widx_q == wlast_q) begin
            state_d = S_DONE;
          end else begin
            addr_d = addr_q + 16'h1;
            widx_d = widx_q + 2'h1;
            state_d = S_PROG;
          end
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      S_DONE: begin
        cmp_d = 1'b1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    // registered copy of the decode so the port comes from a flop
    busy_d = (state_d != S_IDLE);
  end

  // page field selects the erased page
  // a stalled read borrows the port only when idle, never under an erase or program
  assign mif.addr = (state_q == S_IDLE && rd_pend_q) ? rd_addr_q : addr_q;
  assign mif.wdata = data_q[widx_q];
  // the array ands the new data into the old
  assign mif.prog = prog_p;
  assign mif.erase_page = erase_p && !all_q;
  assign mif.erase_all = erase_p && all_q;

  // ahb read path: address phase, two stall cycles for the array read
  always_comb begin
    rd_pend_d = rd_pend_q;
    rd_addr_d = rd_addr_q;
    rvalid_d = 1'b0;
    hrdata_d = hrdata_q;
    hreadyout_d = hreadyout_q;
    if (hsel && hready && htrans[1] && hreadyout_q) begin
      // instruction and data fetches take the same path
      rd_pend_d = 1'b1;
      rd_addr_d = haddr[17:2];
      hreadyout_d = 1'b0;
    end else if (rd_pend_q && state_q == S_IDLE && !rvalid_q) begin
      // read waits until the sequencer is idle
      rvalid_d = 1'b1;
    end else if (rvalid_q) begin
      rd_pend_d = 1'b0;
      hrdata_d = mif.rdata;
      hreadyout_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
      cnt_q <= 32'h0;
      addr_q <= efc_pkg::ADDR_RESET;
      for (int i = 0; i < efc_pkg::BURST_WORDS; i++) data_q[i] <= efc_pkg::DATA_RESET;
      widx_q <= 2'h0;
      wlast_q <= 2'h0;
      all_q <= 1'b0;
      acc_q <= 1'b0;
      cmp_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 16'h0;
      rvalid_q <= 1'b0;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
    end else begin
      state_q <= state_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      data_q <= data_d;
      widx_q <= widx_d;
      wlast_q <= wlast_d;
      all_q <= all_d;
      acc_q <= acc_d;
      cmp_q <= cmp_d;
      rd_pend_q <= rd_pend_d;
      rd_addr_q <= rd_addr_d;
      rvalid_q <= rvalid_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= hreadyout_d;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = efc_pkg::HRESP_OKAY;
  assign command_accepted_flag = acc_q;
  assign command_complete_flag = cmp_q;
  assign busy = busy_q;
  assign prog_addr = addr_q;
endmodule : efc_ctrl
`default_nettype wire

/* dv/efc_monitor.sv */
// checker: port properties of the flash controller
`timescale 1ns/10ps
`default_nettype none
module efc_monitor #(
  parameter int unsigned PROG_CYC = 10
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // type
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic [1:0] hresp, // response
  input wire logic cmd_wr, // strobe
  input wire logic [7:0] cmd_code, // code
  input wire logic complete_clr, // clear
  input wire logic command_accepted_flag, // taken
  input wire logic command_complete_flag, // done
  input wire logic busy // running
);
  localparam int LIM = PROG_CYC + 4;
  logic idle;
  logic ok_code;
  logic take;
  assign idle = !busy && !command_accepted_flag && !command_complete_flag;
  assign ok_code = cmd_code inside {efc_pkg::CMD_PAGE_ERASE, efc_pkg::CMD_ARRAY_CLEAR,
    efc_pkg::CMD_WORD_PROGRAM, efc_pkg::CMD_BURST_PROGRAM};
  assign take = hsel && hready && htrans[1] && hreadyout;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_cmd_taken: assert property (cmd_wr && ok_code && idle |=> command_accepted_flag && busy)
    else $error("valid command not taken");
  chk_bad_code: assert property (cmd_wr && !ok_code && idle |=> !command_accepted_flag)
    else $error("invalid code taken");
  chk_busy_refuse: assert property (busy && cmd_wr && !command_accepted_flag |=> !command_accepted_flag)
    else $error("command taken while busy");
  chk_done_sticky: assert property (command_complete_flag && !complete_clr |=> command_complete_flag)
    else $error("complete flag dropped");
  chk_word_time: assert property (cmd_wr && idle && cmd_code == efc_pkg::CMD_WORD_PROGRAM |=>
    !command_complete_flag [*8] ##[1:LIM] command_complete_flag) else $error("word program time");
  chk_read_wait: assert property (take && !busy |=> !hreadyout ##2 hreadyout)
    else $error("read timing wrong");
  chk_read_stall: assert property (busy && !hreadyout |=> !busy || !hreadyout)
    else $error("read done while busy");
  chk_resp_okay: assert property (hresp == efc_pkg::HRESP_OKAY)
    else $error("response not okay");
  cover property (cmd_wr && idle && cmd_code == efc_pkg::CMD_BURST_PROGRAM);
  cover property (take && busy);
  cover property (cmd_wr && busy);
endmodule : efc_monitor
bind efc_ctrl efc_monitor #(.PROG_CYC(PROG_CYC)) u_efc_monitor (.mclk(mclk), .rst_n(rst_n),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .cmd_wr(cmd_wr), .cmd_code(cmd_code), .complete_clr(complete_clr),
  .command_accepted_flag(command_accepted_flag), .command_complete_flag(command_complete_flag),
  .busy(busy));
`default_nettype wire

/* dv/efc_ahb_master.sv */
// partner: bus master issuing single-word reads
`timescale 1ns/10ps
`default_nettype none
module efc_ahb_master (
  input wire logic mclk, // clock
  input wire logic hreadyout, // slave ready
  input wire logic [31:0] hrdata, // read data
  output logic hsel, // select
  output logic [31:0] haddr, // address
  output logic [1:0] htrans, // type
  output logic hwrite, // reads only
  output logic hready // bus ready
);
  // single slave, so bus ready follows it
  assign hready = hreadyout;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
  end
  task automatic read(input logic [15:0] wa, output logic [31:0] d, output bit ok);
    @(negedge mclk);
    hsel = 1'b1;
    htrans = efc_pkg::HTRANS_NONSEQ;
    haddr = {14'h0, wa, 2'h0};
    @(posedge mclk);
    @(negedge mclk);
    hsel = 1'b0;
    htrans = 2'h0;
    // released lines must not keep the old address
    haddr = ~haddr;
    ok = 1'b0;
    // sample off the launching edge so the slave's registers have settled
    for (int n = 0; n < 300 && !ok; n++) begin
      @(negedge mclk);
      ok = hreadyout === 1'b1;
      d = hrdata;
    end
  endtask : read
endmodule : efc_ahb_master
`default_nettype wire

/* dv/tb.sv */
// testbench: command and read sequences for the flash controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hready, hreadyout, acc, cmp, busy;
  logic [31:0] haddr, hrdata;
  logic [31:0] data_in = 32'hffffffff;
  logic [1:0] htrans, hresp;
  logic cmd_wr = 1'b0, addr_wr = 1'b0, accepted_clr = 1'b0, complete_clr = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] addr_in = 16'h0000, prog_addr;
  logic [3:0] data_wr = 4'h0;
  int error_cnt = 0, compares = 0;
  initial forever #5 mclk = ~mclk;
  efc_ctrl #(.ERASE_CYC(20), .PROG_CYC(10), .STEP_CYC(5)) u_efc_ctrl (.mclk(mclk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .addr_wr(addr_wr), .addr_in(addr_in), .data_wr(data_wr), .data_in(data_in),
    .accepted_clr(accepted_clr), .complete_clr(complete_clr), .command_accepted_flag(acc),
    .command_complete_flag(cmp), .busy(busy), .prog_addr(prog_addr));
  efc_ahb_master u_efc_ahb_master (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready));
  task automatic results();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare
  task automatic wait_flag(input bit sel);
    int n;
    for (n = 0; n < 300 && (sel ? cmp : acc) !== 1'b1; n++) @(negedge mclk);
    compare("flag wait", sel ? cmp : acc, 1'b1);
    if (n == 300) results();
  endtask : wait_flag
  task automatic start(input logic [7:0] c);
    @(negedge mclk);
    cmd_code = c;
    cmd_wr = 1'b1;
    @(negedge mclk);
    cmd_wr = 1'b0;
  endtask : start
  task automatic finish();
    wait_flag(1'b0);
    accepted_clr = 1'b1;
    @(negedge mclk);
    accepted_clr = 1'b0;
    // must be refused: a whole-array clear here would wipe the checked data
    start(efc_pkg::CMD_ARRAY_CLEAR);
    wait_flag(1'b1);
    complete_clr = 1'b1;
    @(negedge mclk);
    complete_clr = 1'b0;
    @(negedge mclk);
    compare("flags after op", {acc, cmp, busy}, 3'b000);
  endtask : finish
  task automatic load(input logic [15:0] a, input logic [127:0] d);
    @(negedge mclk);
    addr_in = a;
    addr_wr = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      addr_wr = 1'b0;
      data_wr = 4'h1 << i;
      data_in = d[32*i +: 32];
    end
    @(negedge mclk);
    data_wr = 4'h0;
  endtask : load
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bit ok;
    u_efc_ahb_master.read(a, d, ok);
    compare("read ready", ok, 1'b1);
    if (!ok) results();
    compare("read data", d, exp);
    compare("read resp", hresp, efc_pkg::HRESP_OKAY);
  endtask : rd
  initial begin
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    compare("idle outputs", {hreadyout, acc, cmp, busy, prog_addr}, 20'h80000);
    start(8'h44);
    compare("bad code", acc, 1'b0);
    load(16'h0000, '1);
    start(efc_pkg::CMD_ARRAY_CLEAR);
    finish();
    rd(16'h0003, efc_pkg::ERASED_WORD);
    load(16'h0003, {96'hffffffff_ffffffff_ffffffff, 32'h0});
    start(efc_pkg::CMD_WORD_PROGRAM);
    finish();
    load(16'h0205, {96'hffffffff_ffffffff_ffffffff, 32'h1234abcd});
    start(efc_pkg::CMD_WORD_PROGRAM);
    finish();
    rd(16'h0205, 32'h1234abcd);
    load(16'h0205, {96'hffffffff_ffffffff_ffffffff, 32'hffff0f0f});
    start(efc_pkg::CMD_WORD_PROGRAM);
    finish();
    rd(16'h0205, 32'h12340b0d);
    load(16'h0210, 128'h44444444_33333333_22222222_11111111);
    start(efc_pkg::CMD_BURST_PROGRAM);
    finish();
    compare("end address", prog_addr, 16'h0213);
    for (int i = 0; i < 4; i++) rd(16'(16'h0210 + i), 32'h11111111 * (i + 1));
    load(16'h0200, '1);
    start(efc_pkg::CMD_PAGE_ERASE);
    rd(16'h0003, 32'h0);
    compare("stall until idle", busy, 1'b0);
    finish();
    rd(16'h0205, efc_pkg::ERASED_WORD);
    rd(16'h0003, 32'h0);
    results();
  end
endmodule : tb
`default_nettype wire
